// [rtl/rcc_ctrl.sv]
// Reset cause recorder and run-mode system clock configuration logic.
// Behaviour
// - External reset sets its flag, clears others.
// - Other reset causes accumulate as sticky flags.
// - Auto gate picks sleep/deep banks in sleep.
// - Run mode always uses run gate bank.
// - Divisor field 26:23 resets to F.
// - PLL divisor below minimum is replaced.
// - Clamp applies only while PLL is used.
// - Divider use bit, forced on with PLL.
// - Bypass selects oscillator, else divided PLL.
`timescale 1ns/1ns
`default_nettype none
module rcc_ctrl #(
  parameter int CAUSES = rcc_pkg::CAUSE_COUNT
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Reset cause pulses, one cycle, from the reset controller.
  input wire logic [CAUSES-1:0] i_cause,
  // Current power mode from the power manager.
  input wire logic [1:0] i_mode,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Gate bank in use: 0 run, 1 sleep, 2 deep sleep.
  output logic [1:0] o_gate_bank,
  // Effective divisor applied to the selected source.
  output logic [3:0] o_eff_div,
  // High when the system clock comes from the divider output.
  output logic o_use_div_eff,
  // High when the system clock source is the oscillator.
  output logic o_osc_src
);
  // Sticky reset cause flags, bit 0 for the external reset input.
  // Software clears them by writing ones; a new cause beats the clear.
  logic [CAUSES-1:0] cause;
  // Writable configuration fields.
  logic auto_gate_select;
  logic [3:0] system_divisor;
  logic use_divider;
  logic bypass;
  // Combinational derived values, registered before they leave the block.
  // Registering them keeps every output glitch free for the clock tree.
  logic [3:0] next_eff_div;
  logic next_use_div;
  logic [1:0] next_bank;
  logic [31:0] next_rdata;
  logic [31:0] cfg_word;

  // Cause recording: external wins and clears, others accumulate.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cause <= '0;
    end else if (i_cause[rcc_pkg::CAUSE_EXT]) begin
      // Only the external flag survives an external reset.
      cause <= CAUSES'(1) << rcc_pkg::CAUSE_EXT;
    end else begin
      // Software writes ones to clear; a new cause beats the clear.
      if (i_wr && i_addr == rcc_pkg::ADDR_RESET_CAUSE) begin
        cause <= (cause & ~i_wdata[CAUSES-1:0]) | i_cause;
      end else begin
        cause <= cause | i_cause;
      end
    end
  end

  // Configuration register writes.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      auto_gate_select <= rcc_pkg::AUTO_GATE_RESET;
      system_divisor <= rcc_pkg::DIV_RESET;
      use_divider <= rcc_pkg::USE_DIV_RESET;
      bypass <= rcc_pkg::BYPASS_RESET;
    end else if (i_wr && i_addr == rcc_pkg::ADDR_RUN_CLOCK_CONFIG) begin
      auto_gate_select <= i_wdata[rcc_pkg::POS_AUTO_GATE];
      system_divisor <= i_wdata[rcc_pkg::POS_DIV_HI:rcc_pkg::POS_DIV_LO];
      use_divider <= i_wdata[rcc_pkg::POS_USE_DIV];
      bypass <= i_wdata[rcc_pkg::POS_BYPASS];
    end
  end

  // Clamp, divider forcing and gate bank choice.
  always_comb begin
    // PLL in use means bypass clear.
    if (!bypass && system_divisor < rcc_pkg::DIV_MIN_PLL) begin
      next_eff_div = rcc_pkg::DIV_MIN_PLL;
    end else begin
      next_eff_div = system_divisor;
    end
    next_use_div = use_divider | ~bypass;
    if (i_mode == rcc_pkg::RCC_RUN || !auto_gate_select) begin
      next_bank = rcc_pkg::BANK_RUN;
    end else if (i_mode == rcc_pkg::RCC_DEEP) begin
      next_bank = rcc_pkg::BANK_DEEP;
    end else begin
      next_bank = rcc_pkg::BANK_SLEEP;
    end
  end

  // Readback image of the configuration register.
  always_comb begin
    // Unimplemented and reserved bits read as zero.
    cfg_word = '0;
    cfg_word[rcc_pkg::POS_AUTO_GATE] = auto_gate_select;
    cfg_word[rcc_pkg::POS_DIV_HI:rcc_pkg::POS_DIV_LO] = system_divisor;
    cfg_word[rcc_pkg::POS_USE_DIV] = use_divider;
    cfg_word[rcc_pkg::POS_BYPASS] = bypass;
    // Read data is zero unless a read hits a mapped register.
    next_rdata = '0;
    if (i_rd && i_addr == rcc_pkg::ADDR_RESET_CAUSE) begin
      next_rdata[CAUSES-1:0] = cause;
    end else if (i_rd && i_addr == rcc_pkg::ADDR_RUN_CLOCK_CONFIG) begin
      next_rdata = cfg_word;
    end
  end

  // Registered outputs.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
      o_gate_bank <= rcc_pkg::BANK_RUN;
      o_eff_div <= rcc_pkg::DIV_RESET;
      o_use_div_eff <= 1'b0;
      o_osc_src <= 1'b1;
    end else begin
      o_rdata <= next_rdata;
      o_gate_bank <= next_bank;
      o_eff_div <= next_eff_div;
      o_use_div_eff <= next_use_div;
      o_osc_src <= bypass;
    end
  end

  // Assertions guarding the behaviour of the block.
  // All of them run on the system clock and rest while reset is low,
  // so no check is evaluated while reset holds the block.
  default clocking chk_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  // An external cause leaves only its own flag standing.
  ext_clears_a: assert property (
    i_cause[rcc_pkg::CAUSE_EXT] |=>
      cause == (CAUSES'(1) << rcc_pkg::CAUSE_EXT))
    else $error("external reset did not clear other causes");

  // Without an external cause or a write, no recorded flag is lost.
  sticky_cause_a: assert property (
    (!i_cause[rcc_pkg::CAUSE_EXT] && !i_wr) |=>
      (cause & $past(cause)) == $past(cause))
    else $error("reset cause flag lost");

  // A write of all ones with no new cause empties the flags.
  cause_clear_a: assert property (
    (i_wr && i_addr == rcc_pkg::ADDR_RESET_CAUSE && i_cause == '0 &&
      i_wdata[CAUSES-1:0] == '1) |=> cause == '0)
    else $error("cause flags not cleared by write");

  // Auto gating in deep sleep hands control to the deep sleep bank.
  deep_bank_a: assert property (
    (auto_gate_select && i_mode == rcc_pkg::RCC_DEEP) |=>
      o_gate_bank == rcc_pkg::BANK_DEEP)
    else $error("deep sleep bank not chosen");

  // Auto gating in sleep, or in the unused mode code, picks the sleep bank.
  sleep_bank_a: assert property (
    (auto_gate_select && i_mode != rcc_pkg::RCC_RUN &&
      i_mode != rcc_pkg::RCC_DEEP) |=>
      o_gate_bank == rcc_pkg::BANK_SLEEP)
    else $error("sleep bank not chosen");

  // Without auto gating the run bank serves every mode.
  manual_gate_a: assert property (
    !auto_gate_select |=> o_gate_bank == rcc_pkg::BANK_RUN)
    else $error("run bank not used without auto gating");

  // Run mode always uses the run bank.
  run_bank_a: assert property (
    (i_mode == rcc_pkg::RCC_RUN) |=> o_gate_bank == rcc_pkg::BANK_RUN)
    else $error("run mode not on run bank");

  // With the PLL as source the divisor never drops below the minimum.
  pll_clamp_a: assert property (
    !bypass |=> o_eff_div >= rcc_pkg::DIV_MIN_PLL)
    else $error("PLL divisor below minimum");

  // The oscillator source takes the programmed divisor unchanged.
  bypass_div_a: assert property (
    bypass |=> o_eff_div == $past(system_divisor))
    else $error("bypass divisor altered");

  // The PLL source forces the divider into use.
  force_div_a: assert property (
    !bypass |=> o_use_div_eff)
    else $error("divider not forced with PLL");

  // The source select output follows the bypass bit one cycle later.
  src_sel_a: assert property (
    1'b1 |=> o_osc_src == $past(bypass))
    else $error("source select wrong");

  // Cover points for the main scenarios.
  // Each one must be reached by the bench for the run to mean much.
  ext_seen_c: cover property (i_cause[rcc_pkg::CAUSE_EXT]);
  clamp_seen_c: cover property (
    !bypass && system_divisor < rcc_pkg::DIV_MIN_PLL);
  sleep_bank_c: cover property (o_gate_bank == rcc_pkg::BANK_SLEEP);
  deep_bank_c: cover property (o_gate_bank == rcc_pkg::BANK_DEEP);
  cause_clear_c: cover property (
    i_wr && i_addr == rcc_pkg::ADDR_RESET_CAUSE && cause != '0);
endmodule
`default_nettype wire

// [rtl/rcc_pkg.sv]
// Package with register map, field layout and reset values for reset cause and clock config.
package rcc_pkg;
  // Register offsets (byte addresses).
  localparam logic [11:0] ADDR_RESET_CAUSE = 12'h05C;
  localparam logic [11:0] ADDR_RUN_CLOCK_CONFIG = 12'h060;
  // Reset cause flag positions.
  localparam int CAUSE_EXT = 0;
  localparam int CAUSE_COUNT = 4;
  // Run clock config field positions.
  localparam int POS_AUTO_GATE = 27;
  localparam int POS_DIV_HI = 26;
  localparam int POS_DIV_LO = 23;
  localparam int POS_USE_DIV = 22;
  localparam int POS_BYPASS = 11;
  // Reset values of the writable fields, and the PLL divisor minimum.
  localparam logic [3:0] DIV_RESET = 4'hF;
  localparam logic [3:0] DIV_MIN_PLL = 4'h3;
  localparam logic BYPASS_RESET = 1'b1;
  localparam logic USE_DIV_RESET = 1'b0;
  localparam logic AUTO_GATE_RESET = 1'b0;
  // PLL output frequency in MHz, divided down for the system clock.
  localparam int PLL_MHZ = 200;
  // Power modes of the controller.
  typedef enum logic [1:0] {
    RCC_RUN,
    RCC_SLEEP,
    RCC_DEEP
  } rcc_mode_e;
  // Gate register bank selection codes.
  localparam logic [1:0] BANK_RUN = 2'h0;
  localparam logic [1:0] BANK_SLEEP = 2'h1;
  localparam logic [1:0] BANK_DEEP = 2'h2;
endpackage

// [verification/rcc_ctrl_tb.sv]
// Self-checking bench for the reset cause and run clock config block.
`timescale 1ns/1ns
`default_nettype none
module reset_cause_and_clock_config_tb;
  // Stimulus and observed signals of the block.
  logic i_clk_sys, i_reset_n, i_wr, i_rd;
  logic [3:0] i_cause;
  logic [1:0] i_mode, o_gate_bank;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] o_eff_div;
  logic o_use_div_eff, o_osc_src;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  rcc_ctrl DUT (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_cause(i_cause), .i_mode(i_mode), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_gate_bank(o_gate_bank), .o_eff_div(o_eff_div),
    .o_use_div_eff(o_use_div_eff), .o_osc_src(o_osc_src));
  // Free-running 100 MHz system clock.
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Prints the verdict and stops the run.
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One-cycle write strobe, then waits for derived outputs to settle.
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk_sys) i_wr <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  // One-cycle read strobe; data is looked at in the following cycle only.
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk_sys) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys) i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  // Compares bank, divisor, divider use and source in one word.
  task outs(input logic [7:0] e);
    #1 chk({24'h0, o_gate_bank, o_eff_div, o_use_div_eff, o_osc_src},
      {24'h0, e});
  endtask
  // One-cycle reset cause pulse.
  task cause(input logic [3:0] c);
    @(posedge i_clk_sys) i_cause <= c;
    @(posedge i_clk_sys) i_cause <= 4'h0;
  endtask
  // Cuts a hung run short.
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      end_sim();
    end
  end
  // Main sequence of register accesses and mode changes.
  initial begin
    {i_reset_n, i_wr, i_rd, i_cause, i_mode} = '0;
    {i_addr, i_wdata} = '0;
    repeat (5) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    outs(8'h3D);
    rd(rcc_pkg::ADDR_RUN_CLOCK_CONFIG, 32'h0780_0800);
    rd(rcc_pkg::ADDR_RESET_CAUSE, 32'h0);
    // PLL in use with a divisor below the minimum.
    wr(rcc_pkg::ADDR_RUN_CLOCK_CONFIG, 32'h0080_0000);
    outs(8'h0E);
    // Oscillator source keeps the small divisor unclamped.
    wr(rcc_pkg::ADDR_RUN_CLOCK_CONFIG, 32'h0080_0800);
    outs(8'h05);
    // Auto gating on: each mode picks its own bank.
    wr(rcc_pkg::ADDR_RUN_CLOCK_CONFIG, 32'h0940_0800);
    for (int m = 0; m < 3; m++) begin
      @(posedge i_clk_sys) i_mode <= 2'(m);
      repeat (2) @(posedge i_clk_sys);
      outs({2'(m), 6'h0B});
    end
    // The unused mode code is treated as sleep.
    @(posedge i_clk_sys) i_mode <= 2'h3;
    repeat (2) @(posedge i_clk_sys);
    outs(8'h4B);
    // Auto gating off: the run bank serves every mode.
    wr(rcc_pkg::ADDR_RUN_CLOCK_CONFIG, 32'h0140_0800);
    for (int m = 0; m < 3; m++) begin
      @(posedge i_clk_sys) i_mode <= 2'(m);
      repeat (2) @(posedge i_clk_sys);
      outs(8'h0B);
    end
    // Unmapped write is ignored and unmapped read gives zero.
    wr(12'h064, 32'hFFFF_FFFF);
    rd(12'h064, 32'h0);
    rd(rcc_pkg::ADDR_RUN_CLOCK_CONFIG, 32'h0140_0800);
    // Non-external causes accumulate, external clears the rest.
    cause(4'h2);
    cause(4'h4);
    rd(rcc_pkg::ADDR_RESET_CAUSE, 32'h6);
    cause(4'h1);
    rd(rcc_pkg::ADDR_RESET_CAUSE, 32'h1);
    // Writing ones clears only the flags that were written.
    cause(4'h8);
    wr(rcc_pkg::ADDR_RESET_CAUSE, 32'h0000_0001);
    rd(rcc_pkg::ADDR_RESET_CAUSE, 32'h8);
    wr(rcc_pkg::ADDR_RESET_CAUSE, 32'h0000_000F);
    rd(rcc_pkg::ADDR_RESET_CAUSE, 32'h0);
    // A mid-run reset restores every reset value.
    @(posedge i_clk_sys) i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    outs(8'h3D);
    rd(rcc_pkg::ADDR_RUN_CLOCK_CONFIG, 32'h0780_0800);
    end_sim();
  end
endmodule
`default_nettype wire
